//--- core/xss_pkg.sv
// Constants for the transceiver status and skip control block
package xss_pkg;
    // Word byte addresses
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_LINK   = 4'h8;
    localparam logic [3:0] OFS_RXCFG  = 4'hC;
    // Control register fields
    localparam int B_EN_RLD  = 7;
    localparam int B_EN_LLD  = 6;
    localparam int B_EN_REMOTE_JABBER = 5;
    localparam int B_SKIP    = 2;
    localparam int B_EN_SQE  = 1;
    localparam int B_FILT    = 0;
    localparam logic [7:0] CTRL_RST  = 8'h01;
    localparam logic [7:0] CTRL_WMSK = 8'hE3;
    // Status register fields
    localparam int B_RLD  = 7;
    localparam int B_LLD  = 6;
    localparam int B_REMOTE_JABBER = 5;
    localparam int B_FARP = 4;
    localparam int B_POL  = 3;
    localparam int B_SQE  = 1;
    localparam logic [7:0] IRQ_MSK = 8'hE2;
    // Link config fields
    localparam int B_LCE  = 7;
    localparam int B_PDN  = 5;
    localparam int B_RXEN = 1;
    localparam int B_TXEN = 0;
    localparam logic [7:0] LINK_RST  = 8'h20;
    localparam logic [7:0] LINK_WMSK = 8'hA3;
    // Receive acceptance fields
    localparam int B_ACPT_BAD   = 0;
    localparam int B_ACPT_SHORT = 1;
    localparam logic [7:0] RXCFG_RST  = 8'h00;
    localparam logic [7:0] RXCFG_WMSK = 8'h03;
    // Packet lengths in bytes
    localparam logic [10:0] LEN_MIN_NORM  = 11'h03C;
    localparam logic [10:0] LEN_MIN_SHORT = 11'h006;
    // Skip completion time
    localparam int CLK_MHZ     = 125;
    localparam int SKIP_MAX_NS = 300;
    localparam int SKIP_CYC    = SKIP_MAX_NS * CLK_MHZ / 1000;
    localparam int PTR_W       = 16;
    typedef enum logic [1:0] {
        XSS_SK_IDLE = 2'b00,
        XSS_SK_MOVE = 2'b01,
        XSS_SK_DONE = 2'b11
    } xss_skip_t;
endpackage

//--- core/xss_top.sv
// Transceiver status, skip and receive acceptance register block
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module xss_top
    import xss_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [3:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output var  logic [31:0]       dat_o,
    output var  logic              ack_o,
    output var  logic              irq_o,
    // Line status sources
    input  wire logic              remote_linkdown_i,
    input  wire logic              local_linkdown_i,
    input  wire logic              remote_jabber_i,
    input  wire logic              compatible_far_port_i,
    input  wire logic              rx_polarity_reversed_i,
    input  wire logic              sqe_pulse_i,
    // Receive read pointer
    input  wire logic              rd_ptr_load_i,
    input  wire logic [PTR_W-1:0]  rd_ptr_val_i,
    input  wire logic [PTR_W-1:0]  rx_wr_ptr_i,
    input  wire logic [PTR_W-1:0]  next_pkt_ptr_i,
    output var  logic [PTR_W-1:0]  rd_ptr_o,
    // Receive acceptance
    input  wire logic              rx_end_i,
    input  wire logic [10:0]       rx_len_i,
    input  wire logic              rx_crc_err_i,
    input  wire logic              rx_align_err_i,
    input  wire logic              rx_accept_all_i,
    input  wire logic              rx_own_frame_i,
    output var  logic              rx_keep_o,
    output var  logic              rx_drop_o,
    output var  logic              rx_short_err_o,
    // Power control
    output var  logic              clk_stop_o,
    output var  logic              rx_enable_o,
    output var  logic              tx_enable_o
);

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0]      dat;
        logic             ack;
        logic             irq;
        logic [7:0]       ctrl;
        logic [7:0]       stat;
        logic [7:0]       link;
        logic [7:0]       rxcfg;
        xss_skip_t        skst;
        logic [PTR_W-1:0] rd_ptr;
        logic             keep;
        logic             drop;
        logic             short_err;
        logic             clk_stop;
    } xss_state_t;

    xss_state_t st_ff;
    xss_state_t nxt_st;

    logic       acc;
    logic       wr_lo;
    logic [7:0] wbyte;
    logic       short_pkt;
    logic       bad_pkt;
    logic       self_drop;

    assign acc   = cyc_i && stb_i && !st_ff.ack;
    assign wr_lo = acc && we_i && sel_i[0];
    assign wbyte = dat_i[7:0];

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.ack      = acc;
        nxt_st.dat      = '0;
        nxt_st.keep     = 1'b0;
        nxt_st.drop     = 1'b0;
        nxt_st.short_err = 1'b0;
        short_pkt       = 1'b0;
        bad_pkt         = 1'b0;
        self_drop       = 1'b0;

        // Register reads; unmapped reads return zero
        if (acc && !we_i) begin
            unique case (adr_i)
                OFS_CTRL:   nxt_st.dat[7:0] = st_ff.ctrl;
                OFS_STATUS: nxt_st.dat[7:0] = st_ff.stat;
                OFS_LINK:   nxt_st.dat[7:0] = st_ff.link;
                OFS_RXCFG:  nxt_st.dat[7:0] = st_ff.rxcfg;
                default:    nxt_st.dat      = '0;
            endcase
        end

        if (wr_lo && adr_i == OFS_CTRL) begin
            nxt_st.ctrl = (wbyte & CTRL_WMSK) | (st_ff.ctrl & ~CTRL_WMSK);
        end
        if (wr_lo && adr_i == OFS_LINK) begin
            nxt_st.link = wbyte & LINK_WMSK;
        end
        if (wr_lo && adr_i == OFS_RXCFG) begin
            nxt_st.rxcfg = wbyte & RXCFG_WMSK;
        end

        nxt_st.stat[B_RLD]  = remote_linkdown_i;
        nxt_st.stat[B_LLD]  = local_linkdown_i;
        nxt_st.stat[B_REMOTE_JABBER] = remote_jabber_i;
        nxt_st.stat[B_FARP] = compatible_far_port_i;
        nxt_st.stat[B_POL]  = rx_polarity_reversed_i;
        // sticky error, writing zero clears, set wins
        if (wr_lo && adr_i == OFS_STATUS && !wbyte[B_SQE]) begin
            nxt_st.stat[B_SQE] = 1'b0;
        end
        if (sqe_pulse_i) begin
            nxt_st.stat[B_SQE] = 1'b1;
        end

        // Normal pointer advance by the buffer controller
        if (rd_ptr_load_i && st_ff.skst == XSS_SK_IDLE) begin
            nxt_st.rd_ptr = rd_ptr_val_i;
        end

        unique case (st_ff.skst)
            XSS_SK_IDLE: begin
                if (wr_lo && adr_i == OFS_CTRL && wbyte[B_SKIP]) begin
                    nxt_st.ctrl[B_SKIP] = 1'b1;
                    nxt_st.skst         = XSS_SK_MOVE;
                end
            end
            XSS_SK_MOVE: begin
                if (st_ff.rd_ptr != rx_wr_ptr_i) begin
                    nxt_st.rd_ptr = next_pkt_ptr_i;
                end
                nxt_st.skst = XSS_SK_DONE;
            end
            XSS_SK_DONE: begin
                nxt_st.ctrl[B_SKIP] = 1'b0;
                nxt_st.skst         = XSS_SK_IDLE;
            end
            default: nxt_st.skst = XSS_SK_IDLE;
        endcase

        nxt_st.irq = |(st_ff.stat & st_ff.ctrl & IRQ_MSK);

        if (st_ff.rxcfg[B_ACPT_SHORT]) begin
            short_pkt = rx_len_i < LEN_MIN_SHORT;
        end else begin
            short_pkt = rx_len_i < LEN_MIN_NORM;
        end
        bad_pkt   = short_pkt || rx_crc_err_i || rx_align_err_i;
        // own frames filtered in accept-all mode
        self_drop = rx_accept_all_i && rx_own_frame_i && st_ff.ctrl[B_FILT];
        // drop bad packets unless accept-bad set
        if (rx_end_i) begin
            nxt_st.short_err = short_pkt;
            if (self_drop || (bad_pkt && !st_ff.rxcfg[B_ACPT_BAD])) begin
                nxt_st.drop = 1'b1;
            end else begin
                nxt_st.keep = 1'b1;
            end
        end

        // stop clocks only after the full sequence
        nxt_st.clk_stop = st_ff.link[B_LCE] && !st_ff.link[B_PDN]
                          && !st_ff.link[B_RXEN] && !st_ff.link[B_TXEN];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff        <= '0;
            st_ff.ctrl   <= CTRL_RST;
            st_ff.link   <= LINK_RST;
            st_ff.rxcfg  <= RXCFG_RST;
            st_ff.skst   <= XSS_SK_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign dat_o          = st_ff.dat;
    assign ack_o          = st_ff.ack;
    assign irq_o          = st_ff.irq;
    assign rd_ptr_o       = st_ff.rd_ptr;
    assign rx_keep_o      = st_ff.keep;
    assign rx_drop_o      = st_ff.drop;
    assign rx_short_err_o = st_ff.short_err;
    assign clk_stop_o     = st_ff.clk_stop;
    assign rx_enable_o    = st_ff.link[B_RXEN];
    assign tx_enable_o    = st_ff.link[B_TXEN];

    ////////////////////////////////////////////////////////////////////
    localparam int SKIP_BOUND = SKIP_CYC;

    property p_rld_irq;
        @(posedge clk_i) disable iff (rst_i)
        (st_ff.ctrl[B_EN_RLD] && st_ff.stat[B_RLD]) |=> irq_o;
    endproperty
    a_rld_irq: assert property (p_rld_irq) else $error("remote linkdown irq missing");

    property p_sqe_irq;
        @(posedge clk_i) disable iff (rst_i)
        (st_ff.ctrl[B_EN_SQE] && st_ff.stat[B_SQE]) |=> irq_o;
    endproperty
    a_sqe_irq: assert property (p_sqe_irq) else $error("sqe irq missing");

    property p_irq_or;
        @(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == |($past(st_ff.stat) & $past(st_ff.ctrl) & IRQ_MSK);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq not gated OR");

    property p_skip_move;
        @(posedge clk_i) disable iff (rst_i)
        (st_ff.skst == XSS_SK_MOVE && rd_ptr_o != rx_wr_ptr_i)
        |=> rd_ptr_o == $past(next_pkt_ptr_i);
    endproperty
    a_skip_move: assert property (p_skip_move) else $error("skip did not move");

    property p_skip_empty;
        @(posedge clk_i) disable iff (rst_i)
        (st_ff.skst == XSS_SK_MOVE && rd_ptr_o == rx_wr_ptr_i) |=> $stable(rd_ptr_o);
    endproperty
    a_skip_empty: assert property (p_skip_empty) else $error("empty pointer moved");

    property p_skip_done;
        @(posedge clk_i) disable iff (rst_i)
        $rose(st_ff.ctrl[B_SKIP]) |-> ##[1:SKIP_BOUND] !st_ff.ctrl[B_SKIP];
    endproperty
    a_skip_done: assert property (p_skip_done) else $error("skip not done in time");

    property p_filt_rst;
        @(posedge clk_i) $fell(rst_i) |-> st_ff.ctrl[B_FILT];
    endproperty
    a_filt_rst: assert property (p_filt_rst) else $error("filter bit not set");

    property p_self_drop;
        @(posedge clk_i) disable iff (rst_i)
        (rx_end_i && rx_accept_all_i && rx_own_frame_i && st_ff.ctrl[B_FILT])
        |=> rx_drop_o && !rx_keep_o;
    endproperty
    a_self_drop: assert property (p_self_drop) else $error("own frame kept");

    // Status is cleared for the cycle after reset, so skip that one
    property p_stat_live;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> st_ff.stat[7:3] == $past({remote_linkdown_i, local_linkdown_i,
            remote_jabber_i, compatible_far_port_i, rx_polarity_reversed_i});
    endproperty
    a_stat_live: assert property (p_stat_live) else $error("status not tracking");

    property p_sqe_set;
        @(posedge clk_i) disable iff (rst_i)
        sqe_pulse_i |=> st_ff.stat[B_SQE];
    endproperty
    a_sqe_set: assert property (p_sqe_set) else $error("sqe not captured");

    property p_bad_drop;
        @(posedge clk_i) disable iff (rst_i)
        (rx_end_i && (rx_crc_err_i || rx_align_err_i) && !st_ff.rxcfg[B_ACPT_BAD])
        |=> rx_drop_o;
    endproperty
    a_bad_drop: assert property (p_bad_drop) else $error("bad packet kept");

    property p_short_len;
        @(posedge clk_i) disable iff (rst_i)
        (rx_end_i && !st_ff.rxcfg[B_ACPT_SHORT] && rx_len_i < LEN_MIN_NORM)
        |=> rx_short_err_o;
    endproperty
    a_short_len: assert property (p_short_len) else $error("short not flagged");

    property p_short_ok;
        @(posedge clk_i) disable iff (rst_i)
        (rx_end_i && st_ff.rxcfg[B_ACPT_SHORT] && rx_len_i >= LEN_MIN_SHORT)
        |=> !rx_short_err_o;
    endproperty
    a_short_ok: assert property (p_short_ok) else $error("six byte packet short");

    property p_pdn;
        @(posedge clk_i) disable iff (rst_i)
        clk_stop_o |-> $past(st_ff.link[B_LCE]) && !$past(st_ff.link[B_PDN]);
    endproperty
    a_pdn: assert property (p_pdn) else $error("clock stop without sequence");

    property p_wake;
        @(posedge clk_i) disable iff (rst_i)
        st_ff.link[B_PDN] |=> !clk_stop_o;
    endproperty
    a_wake: assert property (p_wake) else $error("clocks not restarted");

endmodule
`default_nettype wire

//--- verif/xss_host.sv
// Host model that drives the register port as software would
`timescale 1ns/1ns
`default_nettype none
module xss_host
    import xss_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output var  logic        cyc_o,
    output var  logic        stb_o,
    output var  logic        we_o,
    output var  logic [3:0]  adr_o,
    output var  logic [3:0]  sel_o,
    output var  logic [31:0] dat_o
);
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'h1;
        dat_o <= {24'h0, d & ((a == OFS_CTRL) ? 8'hE7 : (a == OFS_STATUS) ? 8'hFA : 8'hFF)};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        r = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
    endtask
    task automatic rd_status(output logic [7:0] r);
        acc(1'b0, OFS_STATUS, 8'h00, r);
        if (r[B_FARP] !== 1'b1) r = r & 8'h5F;
    endtask
    task automatic skip();
        logic [7:0] t;
        acc(1'b1, OFS_CTRL, 8'h04, t);
    endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the status, skip and acceptance block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import xss_pkg::*;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             cyc, stb, we, ack, irq, keep, drop, shrt, stop, rxen, txen;
    logic [3:0]       adr, sel;
    logic [31:0]      wd, rd;
    logic [4:0]       lvl = 5'h00;
    logic             sqe = 1'b0, ld = 1'b0, rxe = 1'b0;
    logic             crc = 1'b0, aln = 1'b0, all = 1'b0, own = 1'b0;
    logic [PTR_W-1:0] ldv = '0, wrp = '0, nxp = '0, rdp;
    logic [10:0]      len = '0;
    logic [10:0]      lens [4] = '{11'h005, 11'h006, 11'h03B, 11'h03C};
    logic [7:0]       r, c, x;
    logic [1:0]       ex;
    int               n;
    int               num_errors = 0;
    int               samples_checked = 0;

    xss_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .irq_o(irq),
        .remote_linkdown_i(lvl[4]), .local_linkdown_i(lvl[3]), .remote_jabber_i(lvl[2]),
        .compatible_far_port_i(lvl[1]), .rx_polarity_reversed_i(lvl[0]), .sqe_pulse_i(sqe),
        .rd_ptr_load_i(ld), .rd_ptr_val_i(ldv), .rx_wr_ptr_i(wrp), .next_pkt_ptr_i(nxp),
        .rd_ptr_o(rdp), .rx_end_i(rxe), .rx_len_i(len), .rx_crc_err_i(crc),
        .rx_align_err_i(aln), .rx_accept_all_i(all), .rx_own_frame_i(own),
        .rx_keep_o(keep), .rx_drop_o(drop), .rx_short_err_o(shrt), .clk_stop_o(stop),
        .rx_enable_o(rxen), .tx_enable_o(txen));
    xss_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic irq_exp(logic [7:0] ct);
        return |({lvl, 3'b000} & ct & IRQ_MSK);
    endfunction
    function automatic logic [7:0] st_exp();
        return {lvl[1] & lvl[4], lvl[3], lvl[1] & lvl[2], lvl[1], lvl[0], 3'b000};
    endfunction
    // Returns drop and short for config x: bit0 bad, bit1 short, bit2 filter
    function automatic logic [1:0] rx_exp(logic [7:0] cf);
        logic s;
        s = len < (cf[B_ACPT_SHORT] ? LEN_MIN_SHORT : LEN_MIN_NORM);
        return {(own & all & cf[2]) | ((crc | aln | s) & !cf[B_ACPT_BAD]), s};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
    initial begin
        void'($urandom(32'h14AC73A8));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        host.acc(0, OFS_CTRL, 0, r);
        chk(r, CTRL_RST);
        host.acc(0, OFS_LINK, 0, r);
        chk({r, stop, rxen, txen}, {LINK_RST, 3'b000});
        host.acc(0, OFS_RXCFG, 0, r);
        chk(r, RXCFG_RST);
        host.acc(1, 4'h2, 8'hFF, r);
        host.acc(0, 4'h2, 0, r);
        chk(r, 8'h00);
        for (int i = 0; i < 40; i++) begin
            c = 8'($urandom) & 8'hE3;
            host.acc(1, OFS_CTRL, c, r);
            lvl <= 5'($urandom);
            repeat (3) @(posedge clk_i);
            chk(irq, irq_exp(c));
            host.rd_status(r);
            chk(r, st_exp());
            host.acc(0, OFS_CTRL, 0, r);
            chk(r, c);
        end
        host.acc(1, OFS_CTRL, 8'h02, r);
        @(posedge clk_i) sqe <= 1'b1;
        @(posedge clk_i) sqe <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b1);
        host.acc(0, OFS_STATUS, 0, r);
        chk(r[1], 1'b1);
        host.acc(1, OFS_STATUS, 8'h00, r);
        host.acc(0, OFS_STATUS, 0, r);
        chk(r[1], 1'b0);
        for (int e = 0; e < 2; e++) begin
            @(posedge clk_i);
            ld <= 1'b1;
            ldv <= 16'($urandom);
            nxp <= 16'($urandom);
            @(posedge clk_i);
            ld <= 1'b0;
            wrp <= e ? ldv : ~ldv;
            host.skip();
            n = 0;
            do begin
                host.acc(0, OFS_CTRL, 0, r);
                n++;
            end while (r[B_SKIP] !== 1'b0 && n < 20);
            chk(n <= 12, 1'b1);
            chk(rdp, e ? ldv : nxp);
        end
        for (int i = 0; i < 60; i++) begin
            x = (i < 4) ? 8'((i < 2) ? 2 : 0) : 8'($urandom);
            host.acc(1, OFS_RXCFG, x & 8'h03, r);
            host.acc(1, OFS_CTRL, {7'h00, x[2]}, r);
            @(posedge clk_i);
            rxe <= 1'b1;
            len <= (i < 4) ? lens[i] : 11'($urandom_range(80));
            {crc, aln, all, own} <= (i < 4) ? 4'h0 : 4'($urandom);
            @(posedge clk_i);
            rxe <= 1'b0;
            @(negedge clk_i);
            ex = rx_exp(x);
            chk({keep, drop, shrt}, {~ex[1], ex});
        end
        host.acc(1, OFS_LINK, 8'h80, r);
        repeat (2) @(posedge clk_i);
        chk(stop, 1'b1);
        host.acc(1, OFS_LINK, 8'hA3, r);
        repeat (2) @(posedge clk_i);
        chk({stop, rxen, txen}, 3'b011);
        host.acc(1, OFS_LINK, 8'h81, r);
        repeat (2) @(posedge clk_i);
        chk(stop, 1'b0);
        host.acc(1, OFS_LINK, 8'h80, r);
        repeat (2) @(posedge clk_i);
        chk(stop, 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(stop, 1'b0);
        host.acc(0, OFS_CTRL, 0, r);
        chk(r, CTRL_RST);
        summarize();
    end
endmodule
`default_nettype wire
